// >>> hw/csi_pkg.sv
// package: register map, field layout, timing constants and carriers
package csi_pkg;
   // register addresses
   localparam logic [15:0] MODE_ADDR        = 16'hff68;
   localparam logic [15:0] GAP_ADDR         = 16'hff6b;
   localparam logic [15:0] SHIFT_ADDR       = 16'hff6c;
   localparam logic [15:0] XFER_CTRL_ADDR   = 16'hff6d;
   localparam logic [15:0] STATUS_ADDR      = 16'hff6e;
   // mode register fields
   localparam int          MODE_EN_BIT      = 7;
   localparam int          MODE_ORDER_BIT   = 6;
   localparam int          MODE_AUTO_BIT    = 5;
   localparam int          MODE_CLK_HI_BIT  = 1;
   localparam int          MODE_CLK_LO_BIT  = 0;
   localparam logic [7:0]  MODE_WMASK       = 8'he3;
   localparam logic [7:0]  MODE_RESET       = 8'h00;
   // gap register fields
   localparam int          GAP_ON_BIT       = 7;
   localparam logic [7:0]  GAP_WMASK        = 8'h9f;
   localparam logic [7:0]  GAP_RESET        = 8'h00;
   // transfer control fields
   localparam int          XC_RX_BIT        = 7;
   localparam int          XC_STROBE_BIT    = 2;
   localparam int          XC_BUSY_BIT      = 1;
   localparam logic [7:0]  XC_RESET         = 8'h00;
   // gap timing in main-clock periods, minimum in serial clock periods
   localparam int          GAP_UNIT_CYC     = 64;
   localparam int          GAP_MIN_EXTRA    = 28;
   localparam int          GAP_MAX_EXTRA    = 36;
   localparam int          GAP_MIN_SCK      = 2;
   // internal serial clock divider default (source enable pulses per half period)
   localparam int          SCK_HALF_DEFAULT = 4;

   typedef enum logic [1:0] {
      CLK_EXTERNAL,
      CLK_TIMER,
      CLK_PRESCALER
   } clk_src_e;

   typedef struct packed {
      logic       en;
      logic       lsb_first;
      logic       auto_sel;
      clk_src_e   clk_src;
   } mode_s;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [15:0] addr;
      logic [7:0] wdata;
   } bus_req_s;
endpackage : csi_pkg

// >>> hw/byte_fifo.sv
// byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rst,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic             push;
   logic             pop;

   // handshake
   assign in_ready  = (count != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem[rd_ptr];

   // storage
   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   // pointers and fill level
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + AW'(1);
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + AW'(1);
         end
         if (push && !pop) begin
            count <= count + (AW+1)'(1);
         end else if (pop && !push) begin
            count <= count - (AW+1)'(1);
         end
      end
   end
endmodule : byte_fifo

// >>> hw/csi_channel.sv
// clocked three-wire serial channel with mode control and automatic byte gap
`timescale 1ns/1ps
module csi_channel #(
   parameter int FIFO_DEPTH = 16,
   parameter int SCK_HALF   = csi_pkg::SCK_HALF_DEFAULT
) (
   input  wire logic                ref_clk,
   input  wire logic                rst,
   // register port
   input  wire csi_pkg::bus_req_s   bus_req,
   output logic               [7:0] bus_rdata,
   // automatic transmit byte stream
   input  wire logic          [7:0] tx_data,
   input  wire logic                tx_valid,
   output logic                     tx_ready,
   // received byte stream
   output logic               [7:0] rx_data,
   output logic                     rx_valid,
   input  wire logic                rx_ready,
   // internal clock sources as one-cycle enables
   input  wire logic                timer_two_output,
   input  wire logic                prescaler_select,
   // serial pins
   input  wire logic                serial_clock_pin_in,
   output logic                     serial_clock_pin_out,
   output logic                     serial_clock_pin_oe,
   output logic                     serial_out_pin,
   output logic                     serial_out_pin_oe,
   input  wire logic                serial_in_pin,
   output logic                     serial_in_pin_owned,
   input  wire logic                busy_pin,
   output logic                     strobe_pin,
   output logic                     strobe_pin_oe,
   output logic                     transfer_done_flag
);
   typedef enum logic [1:0] {IDLE, SHIFT, GAP} state_e;

   state_e              state;
   csi_pkg::mode_s      mode;
   logic          [7:0] serial_channel_mode;
   logic          [7:0] auto_transfer_gap;
   logic          [7:0] auto_xfer_control;
   logic          [7:0] shift_register;
   logic          [2:0] bit_count;
   logic                sck_level;
   logic          [2:0] ext_sync;
   logic                ext_rise;
   logic                ext_fall;
   logic          [2:0] si_sync;
   logic                si_bit;
   logic          [7:0] half_div;
   logic                int_tick;
   logic                rise;
   logic                fall;
   logic         [11:0] gap_cnt;
   logic         [11:0] gap_target;
   logic                start_plain;
   logic                start_auto;
   logic          [7:0] f_tx_data;
   logic                f_tx_valid;
   logic                f_tx_pop;
   logic                rx_push;
   logic                rx_in_ready;
   logic                done_pulse;
   logic                gap_on;
   logic          [4:0] gap_count;
   logic                busy_ok;

   // reverse bit order for lsb-first data path
   function automatic logic [7:0] order(input logic [7:0] d, input logic lsb);
      logic [7:0] r;
      r = d;
      if (lsb) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = d[7-i];
         end
      end
      return r;
   endfunction : order

   // mode field decode
   assign mode.en        = serial_channel_mode[csi_pkg::MODE_EN_BIT];
   assign mode.lsb_first = serial_channel_mode[csi_pkg::MODE_ORDER_BIT];
   assign mode.auto_sel  = serial_channel_mode[csi_pkg::MODE_AUTO_BIT];
   // clock source decode, low bit ignored when external
   assign mode.clk_src   = !serial_channel_mode[csi_pkg::MODE_CLK_HI_BIT] ? csi_pkg::CLK_EXTERNAL
                         : serial_channel_mode[csi_pkg::MODE_CLK_LO_BIT]  ? csi_pkg::CLK_PRESCALER
                         : csi_pkg::CLK_TIMER;
   assign gap_on    = auto_transfer_gap[csi_pkg::GAP_ON_BIT];
   assign gap_count = auto_transfer_gap[4:0];

   // register writes; reserved mode and gap bits held at zero
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_channel_mode <= csi_pkg::MODE_RESET;
         auto_transfer_gap   <= csi_pkg::GAP_RESET;
         auto_xfer_control   <= csi_pkg::XC_RESET;
      end else if (bus_req.write) begin
         if (bus_req.addr == csi_pkg::MODE_ADDR) begin
            serial_channel_mode <= bus_req.wdata & csi_pkg::MODE_WMASK;
         end else if (bus_req.addr == csi_pkg::GAP_ADDR) begin
            auto_transfer_gap <= bus_req.wdata & csi_pkg::GAP_WMASK;
         end else if (bus_req.addr == csi_pkg::XFER_CTRL_ADDR) begin
            auto_xfer_control <= bus_req.wdata;
         end
      end
   end

   // register reads
   always_comb begin
      if (bus_req.addr == csi_pkg::MODE_ADDR) begin
         bus_rdata = serial_channel_mode;
      end else if (bus_req.addr == csi_pkg::GAP_ADDR) begin
         bus_rdata = auto_transfer_gap;
      end else if (bus_req.addr == csi_pkg::SHIFT_ADDR) begin
         bus_rdata = order(shift_register, mode.lsb_first);
      end else if (bus_req.addr == csi_pkg::XFER_CTRL_ADDR) begin
         bus_rdata = auto_xfer_control;
      end else if (bus_req.addr == csi_pkg::STATUS_ADDR) begin
         bus_rdata = {5'h00, transfer_done_flag, state == GAP, state == SHIFT};
      end else begin
         bus_rdata = 8'h00;
      end
   end

   // three-stage synchronisers for pin inputs
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         ext_sync <= 3'h7;
         si_sync  <= 3'h0;
      end else begin
         ext_sync <= {ext_sync[1:0], serial_clock_pin_in};
         si_sync  <= {si_sync[1:0], serial_in_pin};
      end
   end
   assign ext_rise = ext_sync[1] && !ext_sync[2];
   assign ext_fall = !ext_sync[1] && ext_sync[2];
   assign si_bit   = si_sync[2];

   // internal half-period tick from chosen source
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         half_div <= 8'h00;
      end else if (state != SHIFT) begin
         half_div <= 8'h00;
      end else if ((mode.clk_src == csi_pkg::CLK_TIMER && timer_two_output) ||
                   (mode.clk_src == csi_pkg::CLK_PRESCALER && prescaler_select)) begin
         half_div <= (half_div == 8'(SCK_HALF - 1)) ? 8'h00 : half_div + 8'h01;
      end
   end
   assign int_tick = (mode.clk_src != csi_pkg::CLK_EXTERNAL) &&
                     (half_div == 8'(SCK_HALF - 1)) &&
                     ((mode.clk_src == csi_pkg::CLK_TIMER) ? timer_two_output
                                                           : prescaler_select);

   // serial clock edges, internal or external
   assign fall = (mode.clk_src == csi_pkg::CLK_EXTERNAL) ? ext_fall : (int_tick && sck_level);
   assign rise = (mode.clk_src == csi_pkg::CLK_EXTERNAL) ? ext_rise : (int_tick && !sck_level);

   // internal clock level, idles high
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sck_level <= 1'b1;
      end else if (state != SHIFT || !mode.en) begin
         sck_level <= 1'b1;
      end else if (int_tick) begin
         sck_level <= !sck_level;
      end
   end

   // handshake: busy ignored while gap control owns the interval
   assign busy_ok = gap_on || !auto_xfer_control[csi_pkg::XC_BUSY_BIT] || !busy_pin;

   // transfer start conditions
   assign start_plain = mode.en && !mode.auto_sel && state == IDLE && bus_req.write &&
                        bus_req.addr == csi_pkg::SHIFT_ADDR;
   assign start_auto  = mode.en && mode.auto_sel && state == IDLE && f_tx_valid &&
                        busy_ok;
   assign f_tx_pop    = start_auto;

   // gap length: (n+1)*64 + 28, at least 2*2*SCK_HALF main-clock periods with an internal clock source
   always_comb begin
      gap_target = 12'((32'(gap_count) + 1) * csi_pkg::GAP_UNIT_CYC
                       + csi_pkg::GAP_MIN_EXTRA);
      if (mode.clk_src != csi_pkg::CLK_EXTERNAL &&
          gap_target < 12'(csi_pkg::GAP_MIN_SCK * 2 * SCK_HALF)) begin
         gap_target = 12'(csi_pkg::GAP_MIN_SCK * 2 * SCK_HALF);
      end
   end

   // channel state machine
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state <= IDLE;
      end else if (!mode.en) begin
         state <= IDLE;
      end else begin
         case (state)
            IDLE: begin
               if (start_plain || start_auto) begin
                  state <= SHIFT;
               end
            end
            SHIFT: begin
               if (rise && bit_count == 3'h7) begin
                  state <= (mode.auto_sel && gap_on) ? GAP : IDLE;
               end
            end
            GAP: begin
               if (gap_cnt >= gap_target) begin
                  state <= IDLE;
               end
            end
            default: state <= IDLE;
         endcase
      end
   end

   // gap counter on main clock
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         gap_cnt <= 12'h000;
      end else if (state == GAP) begin
         gap_cnt <= gap_cnt + 12'h001;
      end else begin
         gap_cnt <= 12'h000;
      end
   end

   // bit counter, cleared while disabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bit_count <= 3'h0;
      end else if (!mode.en || state != SHIFT) begin
         bit_count <= 3'h0;
      end else if (rise) begin
         bit_count <= bit_count + 3'h1;
      end
   end

   // shift register: plain register when stopped, shifts when enabled
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         shift_register <= 8'h00;
      end else if (state == IDLE && bus_req.write && bus_req.addr == csi_pkg::SHIFT_ADDR) begin
         shift_register <= order(bus_req.wdata, mode.lsb_first);
      end else if (start_auto) begin
         shift_register <= order(f_tx_data, mode.lsb_first);
      end else if (mode.en && state == SHIFT && rise) begin
         shift_register <= {shift_register[6:0],
                            auto_xfer_control[csi_pkg::XC_RX_BIT] || !mode.auto_sel
                            ? si_bit : 1'b0};
      end
   end

   // serial out latch updates on falling edge; low after a write
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         serial_out_pin <= 1'b0;
      end else if (state == IDLE && bus_req.write && bus_req.addr == csi_pkg::SHIFT_ADDR) begin
         serial_out_pin <= 1'b0;
      end else if (mode.en && state == SHIFT && fall) begin
         serial_out_pin <= shift_register[7];
      end
   end

   // done flag: set wins over software clear by status write
   assign done_pulse = state == SHIFT && rise && bit_count == 3'h7;
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         transfer_done_flag <= 1'b0;
      end else if (done_pulse) begin
         transfer_done_flag <= 1'b1;
      end else if (bus_req.write && bus_req.addr == csi_pkg::STATUS_ADDR) begin
         transfer_done_flag <= 1'b0;
      end
   end

   // received bytes into the stream in automatic receive mode
   assign rx_push = done_pulse && mode.auto_sel && auto_xfer_control[csi_pkg::XC_RX_BIT];

   // strobe pulse after each automatic byte
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         strobe_pin <= 1'b0;
      end else begin
         strobe_pin <= done_pulse && mode.auto_sel &&
                       auto_xfer_control[csi_pkg::XC_STROBE_BIT];
      end
   end

   // pin ownership: three serial lines only when enabled
   assign serial_out_pin_oe    = mode.en;
   assign serial_clock_pin_oe  = mode.en && mode.clk_src != csi_pkg::CLK_EXTERNAL;
   assign serial_clock_pin_out = sck_level;
   assign serial_in_pin_owned  = mode.en && (!mode.auto_sel ||
                                 auto_xfer_control[csi_pkg::XC_RX_BIT]);
   assign strobe_pin_oe        = mode.en && mode.auto_sel &&
                                 auto_xfer_control[csi_pkg::XC_STROBE_BIT];

   // transmit buffer
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) tx_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (tx_data),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .out_data  (f_tx_data),
      .out_valid (f_tx_valid),
      .out_ready (f_tx_pop)
   );

   // receive buffer; drops a byte only if full
   byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_data   (order({shift_register[6:0], si_bit}, mode.lsb_first)),
      .in_valid  (rx_push),
      .in_ready  (rx_in_ready),
      .out_data  (rx_data),
      .out_valid (rx_valid),
      .out_ready (rx_ready)
   );
   logic unused_ok;
   assign unused_ok = rx_in_ready;
endmodule : csi_channel

// >>> verification/csi_channel_sva.sv
// checker for mode control, pin ownership and transfer framing
`timescale 1ns/1ps
module csi_channel_chk (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire csi_pkg::bus_req_s bus_req,
   input wire logic [7:0]        bus_rdata,
   input wire logic              serial_clock_pin_in,
   input wire logic              serial_clock_pin_out,
   input wire logic              serial_clock_pin_oe,
   input wire logic              serial_out_pin,
   input wire logic              serial_out_pin_oe,
   input wire logic              strobe_pin_oe,
   input wire logic              transfer_done_flag
);
   logic [7:0] mode;
   logic [7:0] gap;
   logic [4:0] rises;
   logic [4:0] rises_now;
   logic       sck_q;
   logic       clr;

   // shadow copies of the two control registers
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         mode <= 8'h00;
         gap  <= 8'h00;
      end else if (bus_req.write) begin
         if (bus_req.addr == csi_pkg::MODE_ADDR) mode <= bus_req.wdata & 8'he3;
         if (bus_req.addr == csi_pkg::GAP_ADDR) gap <= bus_req.wdata & 8'h9f;
      end
   end

   // serial clock rises since the last shift, status or mode write
   assign clr = bus_req.write && (bus_req.addr == csi_pkg::SHIFT_ADDR
                || bus_req.addr == csi_pkg::STATUS_ADDR || bus_req.addr == csi_pkg::MODE_ADDR);
   assign rises_now = rises + {4'h0, serial_clock_pin_out & ~sck_q};
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         sck_q <= 1'b1;
         rises <= 5'h00;
      end else begin
         sck_q <= serial_clock_pin_out;
         rises <= clr ? 5'h00 : rises_now;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   chk_mode_read_back: assert property (
      bus_req.read && bus_req.addr == csi_pkg::MODE_ADDR |-> bus_rdata == mode)
      else $error("mode register read differs from written value");
   chk_gap_read_back: assert property (
      bus_req.read && bus_req.addr == csi_pkg::GAP_ADDR |-> bus_rdata == gap)
      else $error("gap register read differs from written value");
   chk_stop_pins_free: assert property (
      !mode[7] |-> !serial_out_pin_oe && !serial_clock_pin_oe && !strobe_pin_oe)
      else $error("pin driven while channel stopped");
   chk_out_drive_en: assert property (serial_out_pin_oe == mode[7])
      else $error("serial out enable does not follow channel enable");
   chk_clk_pin_dir: assert property (
      serial_clock_pin_oe == (mode[7] && mode[1]))
      else $error("serial clock direction does not follow clock source");
   chk_stop_clk_high: assert property (
      !mode[7] && !$past(mode[7]) |-> serial_clock_pin_out)
      else $error("serial clock moves while channel stopped");
   chk_done_eight_edges: assert property (
      $rose(transfer_done_flag) && mode[1] && !mode[5] |-> rises_now == 5'h08)
      else $error("done flag not after eight clock rises");
   chk_out_hold_high: assert property (
      serial_clock_pin_in && $past(serial_clock_pin_in) && $past(serial_out_pin_oe)
      && !$past(bus_req.write) && !$past(bus_req.write, 2) && !mode[5]
      |-> $stable(serial_out_pin))
      else $error("serial out changed while clock high");
endmodule : csi_channel_chk

bind csi_channel csi_channel_chk u_csi_channel_chk (
   .ref_clk, .rst, .bus_req, .bus_rdata, .serial_clock_pin_in, .serial_clock_pin_out,
   .serial_clock_pin_oe,
   .serial_out_pin, .serial_out_pin_oe, .strobe_pin_oe, .transfer_done_flag
);

// >>> verification/periph_model.sv
// peripheral model: samples on rising and presents data on falling serial clock
`timescale 1ns/1ps
module periph_model (
   input  wire logic       rst,
   input  wire logic       sck,
   input  wire logic       sdo,
   input  wire logic [7:0] tx_byte,
   output logic            sdi,
   output logic [7:0]      rx_byte,
   output int              rx_count
);
   logic [7:0] sh_in;
   logic [7:0] sh_out;
   int         bits;

   // frame state cleared as reset ends
   always @(negedge rst) begin
      bits = 0;
      rx_count = 0;
      sdi = 1'b1;
   end
   // next bit out on the falling edge
   always @(negedge sck) begin
      if (bits == 0) sh_out = tx_byte;
      sdi = sh_out[7];
      sh_out = {sh_out[6:0], 1'b0};
   end
   // sample on the rising edge, then after the eighth bit release the line inverted
   always @(posedge sck) begin
      sh_in = {sh_in[6:0], sdo};
      bits = bits + 1;
      if (bits == 8) begin
         bits = 0;
         rx_byte = sh_in;
         rx_count++;
         sdi = ~sdi;
      end
   end
endmodule : periph_model

// >>> verification/tb.sv
// testbench: registers, plain transfers, automatic transfers and byte gap
`timescale 1ns/1ps
module tb;
   logic              ref_clk;
   logic              rst;
   csi_pkg::bus_req_s bus_req;
   logic [7:0]        rdata;
   logic [7:0]        tx_data;
   logic              tx_valid;
   logic              tx_ready;
   logic              rx_ready;
   logic              pulse;
   logic              busy;
   logic              sck_out;
   logic              sck_oe;
   logic              sdo;
   logic              sdi;
   logic              done;
   logic              clr_run;
   logic              ext_sck;
   logic [7:0]        rxd;
   logic              rxv;
   logic [7:0]        peer_rx;
   logic [7:0]        v;
   int                peer_cnt;
   int                run;
   int                max_run;
   int                fail_count = 0;
   int                cmp_count = 0;
   wire               sck = sck_oe ? sck_out : ext_sck; // external clock when released
   logic [7:0]        modes [3] = '{8'h83, 8'hc3, 8'h82};

   csi_channel #(.FIFO_DEPTH(16), .SCK_HALF(2)) u_csi_channel (
      .ref_clk, .rst, .bus_req, .bus_rdata(rdata), .tx_data, .tx_valid, .tx_ready,
      .rx_data(rxd), .rx_valid(rxv), .rx_ready, .timer_two_output(~pulse),
      .prescaler_select(pulse), .serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
      .serial_clock_pin_oe(sck_oe), .serial_out_pin(sdo), .serial_out_pin_oe(),
      .serial_in_pin(sdi), .serial_in_pin_owned(), .busy_pin(busy), .strobe_pin(),
      .strobe_pin_oe(), .transfer_done_flag(done));
   periph_model u_periph_model (
      .rst, .sck, .sdo, .tx_byte(8'h35), .sdi, .rx_byte(peer_rx), .rx_count(peer_cnt));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // source pulses on alternate cycles
   always @(negedge ref_clk) pulse <= rst ? 1'b0 : ~pulse;
   // longest high phase of the serial clock that ended in a fall
   always @(posedge ref_clk) begin
      if (clr_run || sck_out) run <= clr_run ? 0 : run + 1;
      else run <= 0;
      if (clr_run) max_run <= 0;
      else if (!sck_out && run > max_run) max_run <= run;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      bus_req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
      @(negedge ref_clk);
      bus_req.write = 1'b0;
   endtask : wr
   task automatic rdc(input logic [15:0] a, input logic [7:0] e);
      @(negedge ref_clk);
      bus_req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk);
      check(rdata, e);
      @(negedge ref_clk);
      bus_req.read = 1'b0;
   endtask : rdc
   task automatic push(input logic [7:0] d);
      @(negedge ref_clk);
      tx_data = d;
      tx_valid = 1'b1;
      for (int i = 0; i < 50; i++) begin
         @(posedge ref_clk);
         if (tx_ready) break;
      end
      @(negedge ref_clk);
      tx_valid = 1'b0;
   endtask : push
   task automatic auto_run(input logic [7:0] g, input int n, input int lo, input int hi);
      int c0;
      c0 = peer_cnt;
      wr(csi_pkg::GAP_ADDR, g);
      for (int i = 0; i < n; i++) push(8'h40 + 8'(i));
      check({7'h0, tx_ready}, n == 16 ? 8'h00 : 8'h01);
      clr_run = 1'b1;
      wr(csi_pkg::MODE_ADDR, 8'ha3);
      clr_run = 1'b0;
      for (int i = 0; i < 3000 && peer_cnt < c0 + n; i++) @(posedge ref_clk);
      repeat (8) @(posedge ref_clk);
      check(peer_rx, 8'h40 + 8'(n - 1));
      check({7'h0, max_run >= lo && max_run <= hi}, 8'h01);
      wr(csi_pkg::MODE_ADDR, 8'h00);
   endtask : auto_run
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report

   initial begin
      #(20000 * 100);
      fail_count++;
      final_report();
   end
   initial begin
      rst = 1'b1;
      bus_req = '0;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rx_ready = 1'b0;
      busy = 1'b0;
      clr_run = 1'b0;
      ext_sck = 1'b1;
      repeat (16) @(posedge ref_clk);
      @(negedge ref_clk);
      rst = 1'b0;
      rdc(csi_pkg::MODE_ADDR, 8'h00);
      rdc(csi_pkg::GAP_ADDR, 8'h00);
      wr(csi_pkg::MODE_ADDR, 8'hff);
      rdc(csi_pkg::MODE_ADDR, 8'he3);
      wr(csi_pkg::GAP_ADDR, 8'hff);
      rdc(csi_pkg::GAP_ADDR, 8'h9f);
      rdc(16'hff70, 8'h00);
      wr(csi_pkg::MODE_ADDR, 8'h81);
      wr(csi_pkg::MODE_ADDR, 8'h00);
      wr(csi_pkg::SHIFT_ADDR, 8'h5a);
      rdc(csi_pkg::SHIFT_ADDR, 8'h5a);
      repeat (30) @(posedge ref_clk);
      check({7'h0, done}, 8'h00);
      check(8'(peer_cnt), 8'h00);
      for (int k = 0; k < 3; k++) begin
         wr(csi_pkg::MODE_ADDR, modes[k]);
         wr(csi_pkg::STATUS_ADDR, 8'h00);
         wr(csi_pkg::SHIFT_ADDR, 8'h1e);
         for (int i = 0; i < 300 && done !== 1'b1; i++) @(posedge ref_clk);
         check({7'h0, done}, 8'h01);
         check(peer_rx, k == 1 ? 8'h78 : 8'h1e);
         rdc(csi_pkg::SHIFT_ADDR, k == 1 ? 8'hac : 8'h35);
      end
      // external clock transfer driven from the far side
      wr(csi_pkg::MODE_ADDR, 8'h80);
      wr(csi_pkg::STATUS_ADDR, 8'h00);
      wr(csi_pkg::SHIFT_ADDR, 8'h1e);
      repeat (8) begin
         repeat (8) @(negedge ref_clk);
         ext_sck = 1'b0;
         repeat (8) @(negedge ref_clk);
         ext_sck = 1'b1;
      end
      repeat (4) @(posedge ref_clk);
      check({7'h0, done}, 8'h01);
      check(peer_rx, 8'h1e);
      rdc(csi_pkg::SHIFT_ADDR, 8'h35);
      wr(csi_pkg::MODE_ADDR, 8'h00);
      wr(csi_pkg::XFER_CTRL_ADDR, 8'h80);
      auto_run(8'h00, 16, 4, 91);
      check(rxd, 8'h35);
      check({7'h0, rxv}, 8'h01);
      rx_ready = 1'b1;
      busy = 1'b1;
      wr(csi_pkg::XFER_CTRL_ADDR, 8'h82);
      auto_run(8'h80, 2, 96, 112);
      auto_run(8'h82, 2, 224, 240);
      final_report();
   end
endmodule : tb
